/* src/parallel_port_a_b.sv */
// Two 8-bit parallel ports with timer sharing, address bus and segment drivers
`include "parallel_port_defs.svh"

// Contract
// - First port: eight two-way lines, each with a data bit and direction bit.
// - Direction bit one drives the pin as an output.
// - Reset clears the first port direction register to all zeros.
// - First port data register always read/write and untouched by reset.
// - Writes to a data bit under alternate function do not move the pin.
// - First port pins shared with timer captures, compares and pulse accumulator.
// - Second port: eight two-way lines, doubling as address bits 8 to 15.
// - Expanded or test mode: address outputs, second port data and direction registers unmapped; enabled segment drivers still override the address on pins 4 to 7.
// - Single-chip or bootstrap: second port inputs with selectable pull-ups.
// - Four segment drivers may be enabled on second port bits 4 to 7.
// - Second port data register read/write outside expanded and test modes, and kept through reset.
module parallel_port_a_b (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire parallel_port_pkg::op_mode_e mode_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] first_port_pin_in,
  output logic [7:0] first_port_pin_out,
  output logic [7:0] first_port_pin_oe_out,
  input wire logic [7:0] second_port_pin_in,
  output logic [7:0] second_port_pin_out,
  output logic [7:0] second_port_pin_oe_out,
  output logic [7:0] second_port_pullup_out,
  input wire logic [15:8] high_address_in,
  input wire logic [3:0] segment_driver_in,
  input wire logic output_compare_one_in,
  input wire logic output_compare_two_in,
  input wire logic output_compare_three_in,
  input wire logic output_compare_four_in,
  input wire logic output_compare_five_in,
  input wire logic [7:3] output_compare_one_en_in,
  input wire logic capture_four_sel_in,
  output logic input_capture_one_out,
  output logic input_capture_two_out,
  output logic input_capture_three_out,
  output logic input_capture_four_out,
  output logic pulse_accumulator_input_out
);
  import parallel_port_pkg::*;

  // ********************************************************************
  // Register state
  // ********************************************************************
  port_byte_t first_port_pin_data_r;
  port_byte_t first_port_direction_r;
  port_byte_t second_port_pin_data_r;
  port_byte_t second_port_direction_r;
  port_byte_t second_port_pullup_r;
  logic [3:0] segment_enable_r;
  port_byte_t alt_select_r;
  port_byte_t reg_rdata_r;
  port_byte_t reg_rdata_nxt;

  // Pin-side datapath
  port_byte_t timer_drive;
  port_byte_t timer_owns;
  port_byte_t first_port_drive;
  port_byte_t first_port_oe;
  port_byte_t second_port_drive;
  port_byte_t second_port_oe;
  port_byte_t segment_on;
  port_byte_t segment_level;

  // Mode and strobe decode
  logic bus_mode;
  logic second_port_mapped;
  logic wr_first_data;
  logic wr_first_dir;
  logic wr_second_data;
  logic wr_second_dir;
  logic wr_pullup;
  logic wr_segment;
  logic wr_alt;

  // ********************************************************************
  // Mode and address decode
  // ********************************************************************
  // Expanded and test modes hand the second port to the address bus
  assign bus_mode = (mode_in == MODE_EXPANDED) || (mode_in == MODE_TEST);
  assign second_port_mapped = !bus_mode;

  // One strobe per register keeps each update block to a single concern
  assign wr_first_data = reg_wr_in && (reg_addr_in == `PP_OFS_FIRST_DATA);
  assign wr_first_dir = reg_wr_in && (reg_addr_in == `PP_OFS_FIRST_DIR);
  assign wr_second_data = reg_wr_in && second_port_mapped
                          && (reg_addr_in == `PP_OFS_SECOND_DATA);
  assign wr_second_dir = reg_wr_in && second_port_mapped
                         && (reg_addr_in == `PP_OFS_SECOND_DIR);
  assign wr_pullup = reg_wr_in && (reg_addr_in == `PP_OFS_SECOND_PULLUP);
  assign wr_segment = reg_wr_in && (reg_addr_in == `PP_OFS_SEGMENT_EN);
  assign wr_alt = reg_wr_in && (reg_addr_in == `PP_OFS_ALT_SELECT);

  // ********************************************************************
  // First port registers
  // ********************************************************************
  // No reset on purpose: power-up contents stay undefined
  always_ff @(posedge clk_sys_in) begin
    if (wr_first_data) begin
      first_port_pin_data_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      first_port_direction_r <= `PP_DIR_RESET;
    end else if (wr_first_dir) begin
      first_port_direction_r <= reg_wdata_in;
    end
  end

  // ********************************************************************
  // Second port registers and first port alternate select
  // ********************************************************************
  // Unmapped in bus modes, so writes there are dropped
  always_ff @(posedge clk_sys_in) begin
    if (wr_second_data) begin
      second_port_pin_data_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      second_port_direction_r <= `PP_DIR_RESET;
    end else if (wr_second_dir) begin
      second_port_direction_r <= reg_wdata_in;
    end
  end

  // Pull-ups start off so no input is pulled before software asks
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      second_port_pullup_r <= `PP_PULLUP_RESET;
    end else if (wr_pullup) begin
      second_port_pullup_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      segment_enable_r <= `PP_SEGMENT_RESET;
    end else if (wr_segment) begin
      segment_enable_r <= reg_wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      alt_select_r <= `PP_ALT_RESET;
    end else if (wr_alt) begin
      alt_select_r <= reg_wdata_in;
    end
  end

  // ********************************************************************
  // Read port
  // ********************************************************************
  always_comb begin
    reg_rdata_nxt = `PP_UNMAPPED_READ;
    unique case (reg_addr_in)
      `PP_OFS_FIRST_DATA: begin
        reg_rdata_nxt = first_port_pin_data_r;
      end
      `PP_OFS_FIRST_DIR: begin
        reg_rdata_nxt = first_port_direction_r;
      end
      // Second port registers leave the map while the pins carry the address
      `PP_OFS_SECOND_DATA: begin
        if (second_port_mapped) begin
          reg_rdata_nxt = second_port_pin_data_r;
        end
      end
      `PP_OFS_SECOND_DIR: begin
        if (second_port_mapped) begin
          reg_rdata_nxt = second_port_direction_r;
        end
      end
      `PP_OFS_SECOND_PULLUP: begin
        reg_rdata_nxt = second_port_pullup_r;
      end
      `PP_OFS_SEGMENT_EN: begin
        reg_rdata_nxt = {4'h0, segment_enable_r};
      end
      `PP_OFS_ALT_SELECT: begin
        reg_rdata_nxt = alt_select_r;
      end
      default: begin
        reg_rdata_nxt = `PP_UNMAPPED_READ;
      end
    endcase
  end

  // Zero outside the read cycle, so stale data is never taken for an answer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_r <= `PP_UNMAPPED_READ;
    end else if (reg_rd_in) begin
      reg_rdata_r <= reg_rdata_nxt;
    end else begin
      reg_rdata_r <= `PP_UNMAPPED_READ;
    end
  end
  assign reg_rdata_out = reg_rdata_r;

  // ********************************************************************
  // First port and timer sharing
  // ********************************************************************
  // Compare one may join any of bits 3 to 7; bit 3 may instead be capture four
  always_comb begin
    timer_drive = 8'h00;
    timer_owns = 8'h00;
    // Bit 3 belongs to compare five unless capture four has it
    if (alt_select_r[3] && !capture_four_sel_in) begin
      timer_owns[3] = 1'b1;
      timer_drive[3] = output_compare_five_in
                       | (output_compare_one_en_in[3] & output_compare_one_in);
    end
    if (alt_select_r[4]) begin
      timer_owns[4] = 1'b1;
      timer_drive[4] = output_compare_four_in
                       | (output_compare_one_en_in[4] & output_compare_one_in);
    end
    if (alt_select_r[5]) begin
      timer_owns[5] = 1'b1;
      timer_drive[5] = output_compare_three_in
                       | (output_compare_one_en_in[5] & output_compare_one_in);
    end
    if (alt_select_r[6]) begin
      timer_owns[6] = 1'b1;
      timer_drive[6] = output_compare_two_in
                       | (output_compare_one_en_in[6] & output_compare_one_in);
    end
    // Bit 7 has no compare of its own, so compare one takes it alone
    if (output_compare_one_en_in[7]) begin
      timer_owns[7] = 1'b1;
      timer_drive[7] = output_compare_one_in;
    end
  end

  // ********************************************************************
  // Timer inputs
  // ********************************************************************
  // Captures one to three always see the pin so a timer can watch an output too
  assign input_capture_three_out = first_port_pin_in[0];
  assign input_capture_two_out = first_port_pin_in[1];
  assign input_capture_one_out = first_port_pin_in[2];
  // Capture four sees pin 3 only while selected, so compare five can share it
  assign input_capture_four_out = first_port_pin_in[3] & capture_four_sel_in;
  assign pulse_accumulator_input_out = first_port_pin_in[7];

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_first_port
      // Timer owning the pin overrides the data register
      assign first_port_drive[i] = timer_owns[i] ? timer_drive[i]
                                                 : first_port_pin_data_r[i];
      assign first_port_oe[i] = timer_owns[i]
                                | first_port_direction_r[i];
    end
  endgenerate
  assign first_port_pin_out = first_port_drive;
  assign first_port_pin_oe_out = first_port_oe;

  // ********************************************************************
  // Second port: address bus, segment drivers, general I/O
  // ********************************************************************
  // Segment enables line up with pins 4 to 7; the low pins never carry one
  always_comb begin
    segment_on = 8'h00;
    segment_level = 8'h00;
    for (int k = 0; k < 4; k++) begin
      segment_on[k + `PP_SEGMENT_LSB] = segment_enable_r[k];
      segment_level[k + `PP_SEGMENT_LSB] = segment_driver_in[k];
    end
  end

  generate
    for (i = 0; i < 8; i++) begin : g_second_port
      // Segment drive wins in every mode, including over the address bus
      assign second_port_drive[i] = segment_on[i] ? segment_level[i]
                                    : bus_mode ? high_address_in[i + 8]
                                    : second_port_pin_data_r[i];
      assign second_port_oe[i] = segment_on[i] | bus_mode
                                 | second_port_direction_r[i];
      // Pull-ups only make sense on undriven inputs in non-bus modes
      assign second_port_pullup_out[i] = second_port_mapped && second_port_pullup_r[i]
                                         && !second_port_oe[i];
    end
  endgenerate
  assign second_port_pin_out = second_port_drive;
  assign second_port_pin_oe_out = second_port_oe;

  // Second port input value is not latched; only the data register reads back
  logic unused_inputs;
  assign unused_inputs = ^second_port_pin_in;
endmodule

/* src/parallel_port_defs.svh */
// Register offsets, reset values and field positions of the parallel port block
`ifndef PARALLEL_PORT_DEFS_SVH
`define PARALLEL_PORT_DEFS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define PP_OFS_FIRST_DATA 8'h00
`define PP_OFS_FIRST_DIR 8'h01
`define PP_OFS_SECOND_DIR 8'h02
`define PP_OFS_SECOND_DATA 8'h04
`define PP_OFS_SECOND_PULLUP 8'h10
`define PP_OFS_SEGMENT_EN 8'h11
`define PP_OFS_ALT_SELECT 8'h12

// ********************************************************************
// Reset values and fields
// ********************************************************************
`define PP_DIR_RESET 8'h00
`define PP_PULLUP_RESET 8'h00
`define PP_SEGMENT_RESET 4'h0
`define PP_ALT_RESET 8'h00
`define PP_SEGMENT_LSB 4
`define PP_UNMAPPED_READ 8'h00

`endif

/* src/parallel_port_pkg.sv */
// Types shared by the parallel port block
package parallel_port_pkg;
  typedef enum logic [3:0] {
    MODE_SINGLE_CHIP = 4'b0001,
    MODE_EXPANDED = 4'b0010,
    MODE_BOOTSTRAP = 4'b0100,
    MODE_TEST = 4'b1000
  } op_mode_e;
  typedef logic [7:0] port_byte_t;
endpackage

/* verification/parallel_port_a_b_monitor.sv */
// Concurrent checks on the parallel port ports
`include "parallel_port_defs.svh"
module parallel_port_a_b_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire parallel_port_pkg::op_mode_e mode_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] first_port_pin_in,
  input wire logic [7:0] first_port_pin_oe_out,
  input wire logic [7:0] second_port_pin_out,
  input wire logic [7:0] second_port_pin_oe_out,
  input wire logic [7:0] second_port_pullup_out,
  input wire logic [15:8] high_address_in,
  input wire logic [7:3] output_compare_one_en_in,
  input wire logic capture_four_sel_in,
  input wire logic input_capture_one_out,
  input wire logic input_capture_two_out,
  input wire logic input_capture_three_out,
  input wire logic input_capture_four_out,
  input wire logic pulse_accumulator_input_out
);
  import parallel_port_pkg::*;
  logic bus_mode;
  assign bus_mode = mode_in inside {MODE_EXPANDED, MODE_TEST};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ***************
  // Properties
  // ***************
  sequence s_wr_data; reg_wr_in && reg_addr_in == `PP_OFS_FIRST_DATA; endsequence
  // Only with every pin driven, so a pin-level readback cannot differ
  sequence s_rd_data;
    reg_rd_in && reg_addr_in == `PP_OFS_FIRST_DATA && first_port_pin_oe_out == 8'hFF;
  endsequence
  property p_dir_reset;
    $fell(rst_in) && output_compare_one_en_in == 5'h00 |-> first_port_pin_oe_out == 8'h00;
  endproperty
  property p_dir_drive;
    reg_wr_in && reg_addr_in == `PP_OFS_FIRST_DIR
      |=> (first_port_pin_oe_out & $past(reg_wdata_in)) == $past(reg_wdata_in);
  endproperty
  property p_data_back; s_wr_data ##2 s_rd_data |=> reg_rdata_out == $past(reg_wdata_in, 3); endproperty
  property p_hidden_read;
    bus_mode && reg_rd_in && reg_addr_in == `PP_OFS_SECOND_DATA |=> reg_rdata_out == 8'h00;
  endproperty
  property p_addr_out;
    bus_mode |-> second_port_pin_oe_out[3:0] == 4'hF
      && second_port_pin_out[3:0] == high_address_in[11:8];
  endproperty
  property p_captures;
    input_capture_three_out == first_port_pin_in[0] && input_capture_two_out == first_port_pin_in[1]
      && input_capture_one_out == first_port_pin_in[2]
      && pulse_accumulator_input_out == first_port_pin_in[7];
  endproperty
  property p_capture_four; capture_four_sel_in |-> input_capture_four_out == first_port_pin_in[3]; endproperty
  property p_pullup; (second_port_pullup_out & second_port_pin_oe_out) == 8'h00; endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");
  a_dir_drive: assert property (p_dir_drive) else $error("direction one not driving");
  a_data_back: assert property (p_data_back) else $error("first data readback wrong");
  a_hidden_read: assert property (p_hidden_read) else $error("second data visible in bus mode");
  a_addr_out: assert property (p_addr_out) else $error("address bits not on second port");
  a_captures: assert property (p_captures) else $error("capture pins misrouted");
  a_capture_four: assert property (p_capture_four) else $error("capture four misrouted");
  a_pullup: assert property (p_pullup) else $error("pull-up on a driven pin");
endmodule
bind parallel_port_a_b parallel_port_a_b_monitor u_parallel_port_a_b_monitor (.clk_sys_in, .rst_in,
  .mode_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .first_port_pin_in,
  .first_port_pin_oe_out, .second_port_pin_out, .second_port_pin_oe_out, .second_port_pullup_out,
  .high_address_in, .output_compare_one_en_in, .capture_four_sel_in, .input_capture_one_out,
  .input_capture_two_out, .input_capture_three_out, .input_capture_four_out,
  .pulse_accumulator_input_out);

/* verification/pin_side_model.sv */
// External circuitry seen by one 8-bit port
module pin_side_model (
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pullup_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven bits show the pull-up level or else the outside level, so a stale drive value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) level_out[i] = drive_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = ext_in[i];
    end
  end
endmodule

/* verification/tb_top.sv */
// Register-level tests of the parallel port block
`include "parallel_port_defs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import parallel_port_pkg::*;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, c4 = 1'b0;
  logic ic1, ic2, ic3, ic4, pa;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, rdata, fp_in, fp_out, fp_oe, sp_in;
  logic [7:0] sp_out, sp_oe, sp_pu, hi = 8'hC3;
  logic [7:3] oc1_en = 5'h00;
  logic [5:1] oc = 5'h00;
  logic [3:0] seg = 4'h9;
  op_mode_e mode_in = MODE_SINGLE_CHIP;
  op_mode_e bus_modes [2] = '{MODE_EXPANDED, MODE_TEST};
  int n_errors = 0, checks_done = 0, cyc = 0;
  parallel_port_a_b u_parallel_port_a_b (.clk_sys_in, .rst_in, .mode_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out(rdata), .first_port_pin_in(fp_in),
    .first_port_pin_out(fp_out), .first_port_pin_oe_out(fp_oe), .second_port_pin_in(sp_in),
    .second_port_pin_out(sp_out), .second_port_pin_oe_out(sp_oe), .second_port_pullup_out(sp_pu),
    .high_address_in(hi), .segment_driver_in(seg), .output_compare_one_in(oc[1]),
    .output_compare_two_in(oc[2]), .output_compare_three_in(oc[3]), .output_compare_four_in(oc[4]),
    .output_compare_five_in(oc[5]), .output_compare_one_en_in(oc1_en), .capture_four_sel_in(c4),
    .input_capture_one_out(ic1), .input_capture_two_out(ic2), .input_capture_three_out(ic3),
    .input_capture_four_out(ic4), .pulse_accumulator_input_out(pa));
  pin_side_model u_pin_side_model_a (.drive_in(fp_out), .oe_in(fp_oe), .pullup_in(8'h00),
    .ext_in(8'h5A), .level_out(fp_in));
  pin_side_model u_pin_side_model_b (.drive_in(sp_out), .oe_in(sp_oe), .pullup_in(sp_pu),
    .ext_in(8'h00), .level_out(sp_in));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Whole run needs about 55 cycles; the margin covers a stuck task
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    `CHK("oe reset", 8'h00, fp_oe)
    rd(`PP_OFS_FIRST_DIR, 8'h00, "dir reset");
    @(posedge clk_sys_in);
    c4 <= 1'b1;
    wr(`PP_OFS_FIRST_DIR, 8'hFF);
    wr(`PP_OFS_FIRST_DATA, 8'hA5);
    `CHK("drive", {8'hFF, 8'hA5}, {fp_oe, fp_out})
    rd(`PP_OFS_FIRST_DATA, 8'hA5, "data");
    `CHK("captures", 5'h1A, {pa, ic1, ic2, ic3, ic4})
    wr(`PP_OFS_FIRST_DIR, 8'h0F);
    `CHK("inputs", {8'h0F, 8'h55}, {fp_oe, fp_in})
    @(posedge clk_sys_in);
    c4 <= 1'b0;
    oc <= 5'h11;
    oc1_en <= 5'h10;
    wr(`PP_OFS_ALT_SELECT, 8'h08);
    wr(`PP_OFS_FIRST_DATA, 8'h00);
    `CHK("timer pins", 4'hF, {fp_out[7], fp_out[3], fp_oe[7], fp_oe[3]})
    `CHK("capture four gated", 1'b0, ic4)
    $display("test first port done");
    wr(`PP_OFS_SECOND_DATA, 8'h3C);
    wr(`PP_OFS_SECOND_DIR, 8'hFF);
    `CHK("b drive", {8'hFF, 8'h3C}, {sp_oe, sp_out})
    wr(`PP_OFS_SECOND_DIR, 8'h00);
    wr(`PP_OFS_SECOND_PULLUP, 8'hF0);
    `CHK("pull-up", {8'h00, 8'hF0}, {sp_oe, sp_in})
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(`PP_OFS_SECOND_DATA, 8'h3C, "b kept");
    rd(`PP_OFS_FIRST_DATA, 8'h00, "a kept");
    foreach (bus_modes[i]) begin
      @(posedge clk_sys_in);
      mode_in <= bus_modes[i];
      wr(`PP_OFS_SEGMENT_EN, 8'h00);
      `CHK("address", {8'hFF, hi}, {sp_oe, sp_out})
      rd(`PP_OFS_SECOND_DATA, 8'h00, "b hidden");
      wr(`PP_OFS_SEGMENT_EN, 8'h0F);
      `CHK("segments", {seg, hi[3:0]}, sp_out)
    end
    rd(8'h20, `PP_UNMAPPED_READ, "unmapped");
    $display("test second port done");
    test_done();
  end
endmodule
